// ===== shared/cfsv_regs.vh
`ifndef CFSV_REGS_VH
`define CFSV_REGS_VH
// Notes on behaviour
// - Each source fetches vector from fixed address pair
// - Only reset, suspend-end, ports, serial wake halt
// - Equal level: trap, then ascending number, timebase last
// - Context save leaves second index register alone
// - Program counter 16 bits, low/high byte halves
// - Flags register resets with bits 7,6,5,3 set
// - Half carry from bit 3 on add/adc
// - Negative flag copies result bit 7
// - Zero flag set when result is zero
// - Carry from arithmetic, set/clear, shifts, bit tests
// - Mask bits 5,3 encode software priority level
// - Entry loads mask from source priority setting
// - Stack pointer high byte fixed, reset to top
// - Decrement after push, increment before pop
// - Stack pointer wraps silently at both ends
// - Stack reset instruction sets low seven bits
// - Interrupt pushes five bytes, low PC first; call two
// - Reset starts in low power mode, PLL off
// - PHY power-off bit removes transceiver consumption
// - Wait or halt clears both mask bits
// - Reset wake waits 512 cycles before vector fetch

`define CFSV_VEC_RESET     16'hFFFE
`define CFSV_VEC_TRAP      16'hFFFC
`define CFSV_VEC_SRC0      16'hFFFA
`define CFSV_STACK_HI      8'h01
`define CFSV_SP_RESET      16'h01FF
`define CFSV_SP_LO_RESET   8'hFF
`define CFSV_CC_RESET      8'hE8
`define CFSV_CC_H          4
`define CFSV_CC_I1         5
`define CFSV_CC_I0         3
`define CFSV_CC_N          2
`define CFSV_CC_Z          1
`define CFSV_CC_C          0
`define CFSV_WAKE_MASK     12'h3F4
`define CFSV_STAB_CYCLES   512
`define CFSV_NSRC          12
`endif

// ===== verilog/cfsv_prio_pick.v
`timescale 1ns/1ns
`include "cfsv_regs.vh"
// ==========================================
// Highest-level pick among pending sources, ties by lowest number
module cfsv_prio_pick #(
	parameter N = 12
) (
	input  wire [N-1:0] req,
	input  wire [2*N-1:0] lvl,
	input  wire [1:0]   cur_lvl,
	output reg          hit,
	output reg  [3:0]   idx,
	output reg  [1:0]   hit_lvl
);
	integer i;
	always @* begin
		hit = 1'b0;
		idx = 4'h0;
		hit_lvl = 2'd0;
		// Highest level wins; ties go to lowest number
		for (i = N-1; i >= 0; i = i - 1) begin
			if (req[i] && (lvl[2*i +: 2] > cur_lvl) &&
				(!hit || lvl[2*i +: 2] >= hit_lvl)) begin
				hit = 1'b1;
				idx = i[3:0];
				hit_lvl = lvl[2*i +: 2];
			end
		end
	end
endmodule

// ===== verilog/cfsv_core_state.v
`timescale 1ns/1ns
`include "cfsv_regs.vh"
// ==========================================
// Core architectural state
module cfsv_core_state #(
	parameter STAB_CYCLES = `CFSV_STAB_CYCLES
) (
	input  wire        clk,
	input  wire        rstn,
	// Execution unit writes
	input  wire        acc_we,
	input  wire [7:0]  acc_wdata,
	input  wire        idx_x_we,
	input  wire [7:0]  idx_x_wdata,
	input  wire        idx_y_we,
	input  wire [7:0]  idx_y_wdata,
	input  wire        pc_lo_we,
	input  wire        pc_hi_we,
	input  wire [7:0]  pc_byte_wdata,
	input  wire        pc_we,
	input  wire [15:0] pc_wdata,
	input  wire        pc_inc,
	input  wire        cc_we,
	input  wire [7:0]  cc_wdata,
	// ALU result flag update
	input  wire        alu_upd,
	input  wire [7:0]  alu_result,
	input  wire        alu_is_add,
	input  wire [7:0]  alu_opa,
	input  wire [7:0]  alu_opb,
	input  wire        alu_carry_upd,
	input  wire        alu_carry,
	input  wire        set_carry_instr,
	input  wire        clear_carry_instr,
	input  wire        mask_set_instr,
	input  wire        mask_clear_instr,
	// Stack
	input  wire        push,
	input  wire        pop,
	input  wire        call_push,
	input  wire        stack_reset_instr,
	input  wire        sp_we,
	input  wire [7:0]  sp_wdata,
	// Power
	input  wire        wait_for_irq_instr,
	input  wire        halt_instr,
	input  wire        iret,
	input  wire [7:0]  suspend_ctrl_wdata,
	input  wire        suspend_ctrl_we,
	input  wire        pll_on_req,
	input  wire        soft_reset,
	// Interrupt sources and priorities
	input  wire        trap_req,
	input  wire [11:0] irq_req,
	input  wire [23:0] irq_sw_priority_regs,
	input  wire        irq_ack,
	// Outputs
	output reg  [7:0]  acc_q,
	output reg  [7:0]  idx_x_q,
	output reg  [7:0]  idx_y_q,
	output reg  [15:0] program_counter_q,
	output wire [7:0]  prog_count_low_byte,
	output wire [7:0]  prog_count_high_byte,
	output reg  [7:0]  condition_code_q,
	output wire [15:0] stack_pointer,
	output reg  [7:0]  suspend_ctrl_q,
	output wire        phy_power_off,
	output reg         low_power_q,
	output reg         sleep_q,
	output reg         halted_q,
	output wire        irq_pending,
	output reg  [15:0] vector_addr_q,
	output reg         vector_fetch_q,
	output reg  [2:0]  stack_cnt_q,
	output wire [7:0]  stack_byte_sel,
	output reg         stab_wait_q
);
	// ==========================================
	// State
	reg  [7:0]  sp_lo_q;
	reg  [9:0]  stab_cnt_q;
	reg         stab_trap_q;
	wire        hit;
	wire [3:0]  hit_idx;
	wire [1:0]  hit_lvl;
	wire [1:0]  cur_lvl;
	wire [4:0]  lo_sum;
	wire        wake_ok;
	wire        take;

	assign prog_count_low_byte  = program_counter_q[7:0];
	assign prog_count_high_byte = program_counter_q[15:8];
	assign stack_pointer = {`CFSV_STACK_HI, sp_lo_q};
	assign phy_power_off = suspend_ctrl_q[0];

	// Level from mask: 10->0, 01->1, 00->2, 11->3
	assign cur_lvl = {~(condition_code_q[`CFSV_CC_I1] ^ condition_code_q[`CFSV_CC_I0]),
		condition_code_q[`CFSV_CC_I0]};

	cfsv_prio_pick #(
		.N       (`CFSV_NSRC)
	) u_pick (
		.req     (irq_req),
		.lvl     (irq_sw_priority_regs),
		.cur_lvl (cur_lvl),
		.hit     (hit),
		.idx     (hit_idx),
		.hit_lvl (hit_lvl)
	);

	assign wake_ok = |(irq_req & `CFSV_WAKE_MASK);
	assign irq_pending = trap_req | hit;
	assign take = irq_ack & irq_pending & !stab_wait_q;
	// Byte to store: PROG_COUNT_LOW_BYTE, PROG_COUNT_HIGH_BYTE, X, A, CC; Y never stacked
	assign stack_byte_sel = (stack_cnt_q == 3'd0) ? program_counter_q[7:0] :
		(stack_cnt_q == 3'd1) ? program_counter_q[15:8] :
		(stack_cnt_q == 3'd2) ? idx_x_q :
		(stack_cnt_q == 3'd3) ? acc_q : condition_code_q;
	assign lo_sum = {1'b0, alu_opa[3:0]} + {1'b0, alu_opb[3:0]} +
		{4'h0, alu_is_add & condition_code_q[`CFSV_CC_C] & alu_carry_upd};

	always @(posedge clk) begin
		if (!rstn || soft_reset) begin
			acc_q <= 8'h00;
			idx_x_q <= 8'h00;
			idx_y_q <= 8'h00;
			program_counter_q <= 16'h0000;
			condition_code_q <= `CFSV_CC_RESET;
			sp_lo_q <= `CFSV_SP_LO_RESET;
			suspend_ctrl_q <= 8'h00;
			low_power_q <= 1'b1;
			sleep_q <= 1'b0;
			halted_q <= 1'b0;
			vector_addr_q <= `CFSV_VEC_RESET;
			vector_fetch_q <= 1'b0;
			stack_cnt_q <= 3'd0;
			stab_wait_q <= soft_reset ? (sleep_q) : 1'b0;
			stab_cnt_q <= 10'd0;
			stab_trap_q <= 1'b0;
		end else begin
			vector_fetch_q <= 1'b0;
			if (acc_we) acc_q <= acc_wdata;
			if (idx_x_we) idx_x_q <= idx_x_wdata;
			if (idx_y_we) idx_y_q <= idx_y_wdata;
			if (pc_we) program_counter_q <= pc_wdata;
			else if (pc_lo_we) program_counter_q[7:0] <= pc_byte_wdata;
			else if (pc_hi_we) program_counter_q[15:8] <= pc_byte_wdata;
			else if (pc_inc) program_counter_q <= program_counter_q + 16'h0001;
			if (suspend_ctrl_we) suspend_ctrl_q <= suspend_ctrl_wdata;
			if (pll_on_req) low_power_q <= 1'b0;
			// Flags: only the addressed bits move
			if (cc_we) begin
				condition_code_q <= cc_wdata;
			end else begin
				if (alu_upd) begin
					condition_code_q[`CFSV_CC_N] <= alu_result[7];
					condition_code_q[`CFSV_CC_Z] <= (alu_result == 8'h00);
					if (alu_is_add)
						condition_code_q[`CFSV_CC_H] <= lo_sum[4];
				end
				if (set_carry_instr) condition_code_q[`CFSV_CC_C] <= 1'b1;
				else if (clear_carry_instr) condition_code_q[`CFSV_CC_C] <= 1'b0;
				else if (alu_carry_upd) condition_code_q[`CFSV_CC_C] <= alu_carry;
				if (mask_set_instr) begin
					condition_code_q[`CFSV_CC_I1] <= 1'b1;
					condition_code_q[`CFSV_CC_I0] <= 1'b1;
				end else if (mask_clear_instr || wait_for_irq_instr || halt_instr) begin
					condition_code_q[`CFSV_CC_I1] <= 1'b0;
					condition_code_q[`CFSV_CC_I0] <= 1'b0;
				end
			end
			if (wait_for_irq_instr) sleep_q <= 1'b1;
			if (halt_instr) begin
				sleep_q <= 1'b1;
				halted_q <= 1'b1;
			end
			// Halt wakes only on eligible sources
			if (sleep_q && ((halted_q && wake_ok) || (!halted_q && irq_pending))) begin
				sleep_q <= 1'b0;
				halted_q <= 1'b0;
			end
			// Stack pointer moves; low byte wraps in 8 bits
			if (stack_reset_instr) sp_lo_q <= sp_lo_q | 8'h7F;
			else if (sp_we) sp_lo_q <= sp_wdata;
			else if (push || call_push || stack_cnt_q != 3'd0 || take)
				sp_lo_q <= sp_lo_q - 8'h01;
			else if (pop || iret) sp_lo_q <= sp_lo_q + 8'h01;
			// Context push sequence, five bytes
			if (take) stack_cnt_q <= 3'd1;
			else if (stack_cnt_q == 3'd4) begin
				stack_cnt_q <= 3'd0;
				vector_fetch_q <= 1'b1;
			end else if (stack_cnt_q != 3'd0) stack_cnt_q <= stack_cnt_q + 3'd1;
			if (take) begin
				if (trap_req) vector_addr_q <= `CFSV_VEC_TRAP;
				else begin
					vector_addr_q <= `CFSV_VEC_SRC0 - {11'h000, hit_idx, 1'b0};
					condition_code_q[`CFSV_CC_I1] <= ~(hit_lvl[1] ^ hit_lvl[0]);
					condition_code_q[`CFSV_CC_I0] <= hit_lvl[0];
				end
			end
			// Stabilisation delay before the reset vector
			if (stab_wait_q) begin
				if (stab_cnt_q == STAB_CYCLES - 1) begin
					stab_wait_q <= 1'b0;
					stab_cnt_q <= 10'd0;
					vector_addr_q <= `CFSV_VEC_RESET;
					vector_fetch_q <= 1'b1;
				end else stab_cnt_q <= stab_cnt_q + 10'd1;
			end
			stab_trap_q <= 1'b0;
		end
	end
endmodule

// ===== sim/cfsv_irq_src.sv
`timescale 1ns/1ns
// ==========================================
// Peripheral request latches
module cfsv_irq_src (
	input  wire        clk,
	input  wire        rstn,
	input  wire [11:0] set_req,
	input  wire        vec_fetch,
	input  wire [15:0] vec_addr,
	output reg  [11:0] irq_req
);
	wire [15:0] slot = (16'hfffa - vec_addr) >> 1;
	always @(posedge clk) begin
		if (!rstn)
			irq_req <= 12'h000;
		else if (vec_fetch && vec_addr <= 16'hfffa)
			irq_req <= (irq_req | set_req) & ~(12'h001 << slot);
		else
			irq_req <= irq_req | set_req;
	end
endmodule

// ===== sim/cfsv_core_state_properties.sv
`timescale 1ns/1ns
// ==========================================
// Port checks
module cfsv_core_state_properties (
	input wire        clk,
	input wire        rstn,
	input wire        push,
	input wire        pop,
	input wire        call_push,
	input wire        sp_we,
	input wire        stack_reset_instr,
	input wire        irq_ack,
	input wire        irq_pending,
	input wire        stab_wait_q,
	input wire        wait_for_irq_instr,
	input wire        halt_instr,
	input wire        mask_set_instr,
	input wire        cc_we,
	input wire        soft_reset,
	input wire        suspend_ctrl_we,
	input wire [7:0]  suspend_ctrl_wdata,
	input wire        phy_power_off,
	input wire [15:0] stack_pointer,
	input wire [7:0]  condition_code_q,
	input wire        vector_fetch_q,
	input wire [2:0]  stack_cnt_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	wire quiet = !pop && !sp_we && !stack_reset_instr && !irq_ack && !call_push && !stack_cnt_q;
	chk_sp_page: assert property (stack_pointer[15:8] == 8'h01)
		else $error("stack page moved");
	chk_push_dec: assert property (
		push && quiet |=> stack_pointer[7:0] == $past(stack_pointer[7:0]) - 8'h01)
		else $error("push step wrong");
	chk_rsp_top: assert property (stack_reset_instr |=> stack_pointer[6:0] == 7'h7f)
		else $error("stack reset wrong");
	chk_sleep_masks: assert property (
		(wait_for_irq_instr || halt_instr) && !mask_set_instr && !irq_ack && !cc_we && !soft_reset
		|=> !condition_code_q[5] && !condition_code_q[3])
		else $error("masks kept in sleep");
	chk_stab_hold: assert property (stab_wait_q |-> !vector_fetch_q)
		else $error("fetch during settle");
	chk_ctx_five: assert property (
		irq_ack && irq_pending && !stab_wait_q && !stack_cnt_q |-> ##5 vector_fetch_q
		&& stack_pointer[7:0] == $past(stack_pointer[7:0], 5) - 8'h05)
		else $error("context push wrong");
	chk_phy_off: assert property (
		suspend_ctrl_we && !soft_reset |=> phy_power_off == $past(suspend_ctrl_wdata[0]))
		else $error("phy off wrong");
	chk_reset_val: assert property (disable iff (1'b0) !rstn |=>
		stack_pointer == 16'h01ff && condition_code_q[7:5] == 3'h7 && condition_code_q[3])
		else $error("reset value wrong");
	cover property (irq_ack && irq_pending);
	cover property (stack_pointer == 16'h0100);
	cover property (stab_wait_q);
endmodule
bind cfsv_core_state cfsv_core_state_properties u_cfsv_core_state_properties (.*);

// ===== sim/cpu_flags_stack_vectors_tb_top.sv
`timescale 1ns/1ns
module cpu_flags_stack_vectors_tb_top;
	logic clk, rstn, acc_we, idx_x_we, idx_y_we, pc_lo_we, pc_hi_we, pc_we, pc_inc, cc_we;
	logic alu_upd, alu_is_add, alu_carry_upd, alu_carry, set_carry_instr, clear_carry_instr;
	logic mask_set_instr, mask_clear_instr, push, pop, call_push, stack_reset_instr, sp_we;
	logic wait_for_irq_instr, halt_instr, iret, suspend_ctrl_we, pll_on_req, soft_reset;
	logic trap_req, irq_ack, phy_power_off, low_power_q, sleep_q, halted_q, irq_pending;
	logic vector_fetch_q, stab_wait_q;
	logic [7:0] acc_wdata, idx_x_wdata, idx_y_wdata, pc_byte_wdata, cc_wdata, alu_result;
	logic [7:0] alu_opa, alu_opb, sp_wdata, suspend_ctrl_wdata, acc_q, idx_x_q, idx_y_q;
	logic [7:0] prog_count_low_byte, prog_count_high_byte, condition_code_q, suspend_ctrl_q;
	logic [7:0] stack_byte_sel;
	logic [15:0] pc_wdata, program_counter_q, stack_pointer, vector_addr_q;
	logic [11:0] irq_req, set_req;
	logic [23:0] irq_sw_priority_regs;
	logic [2:0] stack_cnt_q;
	// Rows: result, opa, opb, add, expected {h, n, z}
	logic [27:0] rows [5] = '{28'h100_808c, 28'h000_0005, 28'h800_0006, 28'h008_0809,
		28'hff0_ff0a};
	int n_fail = 0, n_checks = 0, cyc = 0, i, k;
	cfsv_core_state #(.STAB_CYCLES(8)) u_cfsv_core_state (.*);
	cfsv_irq_src u_cfsv_irq_src (.clk(clk), .rstn(rstn), .set_req(set_req),
		.vec_fetch(vector_fetch_q), .vec_addr(vector_addr_q), .irq_req(irq_req));
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	task clr; begin
		{acc_we, idx_x_we, idx_y_we, pc_lo_we, pc_hi_we, pc_we, pc_inc, cc_we, alu_upd} = '0;
		{alu_carry_upd, set_carry_instr, clear_carry_instr, mask_set_instr, mask_clear_instr} = '0;
		{push, pop, call_push, stack_reset_instr, sp_we, wait_for_irq_instr, halt_instr} = '0;
		{iret, suspend_ctrl_we, pll_on_req, soft_reset, trap_req, irq_ack, set_req} = '0;
	end endtask
	// Strobe for one edge, then let one idle edge pass
	task step; begin
		@(posedge clk);
		#1 clr;
		@(posedge clk);
		#1;
	end endtask
	task wait_vec; begin
		for (k = 0; k < 600 && vector_fetch_q !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
	end endtask
	task chk(input logic [15:0] got, input logic [15:0] exp); begin
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	end endtask
	task end_of_test; begin
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			end_of_test;
		end
	end
	initial begin
		clr;
		{acc_wdata, idx_x_wdata, idx_y_wdata, pc_byte_wdata, cc_wdata, alu_result} = '0;
		{alu_opa, alu_opb, sp_wdata, suspend_ctrl_wdata, pc_wdata, alu_is_add, alu_carry} = '0;
		irq_sw_priority_regs = 24'hff_ffff;
		rstn = 0;
		repeat (12) @(posedge clk);
		#1 rstn = 1;
		chk(stack_pointer, 16'h01ff);
		chk(condition_code_q & 8'he8, 16'h00e8);
		chk(low_power_q, 1'b1);
		for (i = 0; i < 5; i++) begin
			{alu_result, alu_opa, alu_opb, alu_is_add} = rows[i][27:3];
			alu_upd = 1;
			step;
			chk({condition_code_q[4], condition_code_q[2:1]}, rows[i][2:0]);
		end
		chk(condition_code_q & 8'he8, 16'h00e8);
		set_carry_instr = 1;
		step;
		chk(condition_code_q[0], 1'b1);
		clear_carry_instr = 1;
		step;
		chk(condition_code_q[0], 1'b0);
		push = 1;
		step;
		chk(stack_pointer, 16'h01fe);
		pop = 1;
		step;
		pop = 1;
		step;
		chk(stack_pointer, 16'h0100);
		push = 1;
		step;
		chk(stack_pointer, 16'h01ff);
		sp_wdata = 8'h80;
		sp_we = 1;
		step;
		stack_reset_instr = 1;
		step;
		chk(stack_pointer, 16'h01ff);
		pc_byte_wdata = 8'h34;
		pc_lo_we = 1;
		step;
		pc_byte_wdata = 8'h12;
		pc_hi_we = 1;
		suspend_ctrl_wdata = 8'h01;
		suspend_ctrl_we = 1;
		idx_y_wdata = 8'h5a;
		idx_y_we = 1;
		step;
		chk({prog_count_high_byte, prog_count_low_byte}, 16'h1234);
		chk(program_counter_q, 16'h1234);
		chk(phy_power_off, 1'b1);
		wait_for_irq_instr = 1;
		set_req = 12'h210;
		step;
		chk({condition_code_q[5], condition_code_q[3]}, 2'h0);
		chk(irq_pending, 1'b1);
		irq_ack = 1;
		step;
		wait_vec;
		chk(vector_addr_q, 16'hfff2);
		chk(stack_pointer, 16'h01fa);
		chk({condition_code_q[5], condition_code_q[3]}, 2'h3);
		chk(idx_y_q, 8'h5a);
		halt_instr = 1;
		step;
		chk({condition_code_q[5], condition_code_q[3]}, 2'h0);
		chk(irq_pending, 1'b1);
		irq_ack = 1;
		step;
		wait_vec;
		chk(vector_addr_q, 16'hffe8);
		trap_req = 1;
		irq_ack = 1;
		step;
		wait_vec;
		chk(vector_addr_q, 16'hfffc);
		chk(stack_pointer, 16'h01f0);
		halt_instr = 1;
		step;
		soft_reset = 1;
		step;
		chk(stab_wait_q, 1'b1);
		wait_vec;
		chk(vector_addr_q, 16'hfffe);
		chk(k > 4, 1'b1);
		end_of_test;
	end
endmodule
